// ### spo_cfg.svh
// Purpose: Constants for the setpoint output block: offsets, resets, timing
// Assumes: 100 MHz mclk, 32-bit Avalon-MM register words
// Notes:   Included by the design file by its bare name
`ifndef SPO_CFG_SVH
`define SPO_CFG_SVH

// ==========================================================================
// Register byte offsets
`define SPO_OFS_CTRL    6'h00
`define SPO_OFS_SP1     6'h04
`define SPO_OFS_SP2     6'h08
`define SPO_OFS_PULSE1  6'h0c
`define SPO_OFS_PULSE2  6'h10
`define SPO_OFS_COUNT   6'h14
`define SPO_OFS_TOTAL   6'h18
`define SPO_OFS_DISP    6'h1c
`define SPO_OFS_STATUS  6'h20

// ==========================================================================
// Field positions in the control word
`define SPO_CTRL_MODE_LSB 0
`define SPO_CTRL_DOWN_BIT 3

// ==========================================================================
// Reset values
`define SPO_RST_SP      24'h000000
`define SPO_RST_PULSE   14'h0000
`define SPO_RST_MODE    3'h0

// ==========================================================================
// Pulse time range and timing
`define SPO_PULSE_MAX   14'h270f
`define SPO_CLK_NS      10
`define SPO_UNIT_NS     1000000
`define SPO_TICK_CYC    ((`SPO_UNIT_NS + `SPO_CLK_NS - 1) / `SPO_CLK_NS)

`endif

// ### spo_pkg.sv
// Purpose: Types shared by the setpoint output block
// Assumes: Nothing beyond the constants header
// Notes:   Mode codes follow declaration order, 0 to 5
package spo_pkg;

  // ========================================================================
  // Output functions: three manual, three automatic reset modes
  typedef enum logic [2:0] {
    SPO_MR1,
    SPO_MR2,
    SPO_MR3,
    SPO_AR1,
    SPO_AR2,
    SPO_AR3
  } spo_mode_t;

  // ========================================================================
  // Software configuration
  typedef struct packed {
    spo_mode_t   mode;   // Output function
    logic        down;   // Count direction, 1 = downcount
    logic [23:0] sp1;    // First setpoint
    logic [23:0] sp2;    // Second setpoint
    logic [13:0] p1;     // Output one pulse time
    logic [13:0] p2;     // Output two pulse time
  } spo_cfg_t;

  // ========================================================================
  // Field inputs
  typedef struct packed {
    logic count;   // Count pulse
    logic pause;   // Pause level
    logic mreset;  // Manual reset pulse, acts on rising edge
  } spo_pins_t;

endpackage

// ### spo_setpoint_out.sv
// Purpose: Setpoint compare, output pulse timing, reset modes, total count
// Assumes: Field inputs are asynchronous; count pulses slower than 2 mclk
// Notes:   Registers reached over Avalon-MM with one wait cycle per access
`timescale 1ns/1ps
`include "spo_cfg.svh"

// Contract
// - Output one at first setpoint, held if zero
// - Nonzero pulse one ends output one
// - Manual one downcount: output two, continue below
// - Manual two upcount: halt at second setpoint
// - Manual two downcount: halt at zero
// - Manual three: output two timed, keep counting
// - Output two pulse end drops output one
// - Zero pulse one held until reset/output two
// - Manual reset adds count to total
// - Automatic reset adds count to total
// - Auto one upcount: reset count at once
// - Auto one downcount: reload second setpoint at once
// - Automatic reset only with nonzero pulse two
// - Auto two upcount: halt, reset at pulse end
// - Auto two downcount: halt, reload at pulse end
// - Auto three: display holds endpoint during output two
// - Reset leaves zero up, setpoint two down
// - Pulse times range zero to 9999
module spo_setpoint_out
  import spo_pkg::*;
#(
  parameter int TICK_CYC = `SPO_TICK_CYC  // Cycles per pulse time unit
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Field inputs, asynchronous
  input  wire spo_pins_t   field_in,
  // Output modules and display
  output logic             out1_on,
  output logic             out2_on,
  output logic      [23:0] disp_value
);

  // ========================================================================
  // Declarations
  spo_pins_t   s1_q, s2_q, s3_q;   // Synchroniser and edge stages
  spo_cfg_t    cfg_q;              // Software configuration
  logic [23:0] cnt_q;              // Live count, two's complement
  logic [31:0] tot_q;              // Accumulated total count
  logic        out1_q, out2_q;     // Output states
  logic [13:0] t1_q, t2_q;         // Pulse timers
  logic        halt_q;             // Counting stopped at end point
  logic        hold_q;             // Display shows end point
  logic [23:0] disp_q;             // Display register
  logic [31:0] tick_cnt_q;         // Time unit divider
  logic        ack_q;              // Bus answer cycle
  logic [31:0] rdata_q;            // Bus read data
  logic        tick;               // One-cycle time unit strobe
  logic        step, mres;         // Count and reset events
  logic        is_auto, auto_en;   // Automatic reset selection
  logic        p2_used;            // Output two pulse time honoured
  logic [23:0] endpt, reload;      // Direction-dependent points
  logic [23:0] cnt_step, cnt_nx;   // Next count candidates
  logic        adv;                // Count really moves
  logic        hit1, hit2;         // Setpoint reached this cycle
  logic        p1_end, p2_end;     // Pulse times elapsed
  logic        ar_now, ar_late;    // Automatic reset moments
  logic        set_halt;           // Stop counting at end point
  logic        req;                // Bus request present

  // ========================================================================
  // Input synchroniser; the second and third stages feed logic
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= field_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Rising edges; pause blocks counting, not resets
  assign step = s2_q.count & ~s3_q.count & ~s2_q.pause;
  assign mres = s2_q.mreset & ~s3_q.mreset;

  // ========================================================================
  // Time unit tick
  // fixed tick divider
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_q <= 32'h0;
    else if (tick)
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= tick_cnt_q + 32'h1;
  end

  assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));

  // ========================================================================
  // Mode decode and compare
  always_comb
  begin
    is_auto  = (cfg_q.mode == SPO_AR1) | (cfg_q.mode == SPO_AR2)
             | (cfg_q.mode == SPO_AR3);
    auto_en  = is_auto & (cfg_q.p2 != 14'h0);
    // Manual one and two ignore pulse two
    p2_used  = (cfg_q.mode == SPO_MR3) | is_auto;
    endpt    = cfg_q.down ? 24'h000000 : cfg_q.sp2;
    reload   = cfg_q.down ? cfg_q.sp2 : 24'h000000;
    cnt_step = cfg_q.down ? cnt_q - 24'h1 : cnt_q + 24'h1;
    adv      = step & ~halt_q;
    cnt_nx   = adv ? cnt_step : cnt_q;
    hit1     = adv & (cnt_step == cfg_q.sp1);
    hit2     = adv & (cnt_step == endpt);
    p1_end   = out1_q & (cfg_q.p1 != 14'h0) & tick & (t1_q == 14'h1);
    p2_end   = out2_q & p2_used & (cfg_q.p2 != 14'h0) & tick & (t2_q == 14'h1);
    // immediate reset in auto one and three
    ar_now   = hit2 & auto_en & ((cfg_q.mode == SPO_AR1) | (cfg_q.mode == SPO_AR3));
    // auto two resets at pulse end
    ar_late  = p2_end & (cfg_q.mode == SPO_AR2);
    // manual two and auto two stop
    set_halt = hit2 & ((cfg_q.mode == SPO_MR2) | ((cfg_q.mode == SPO_AR2) & auto_en));
  end

  // ========================================================================
  // Count register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 24'h000000;
    else if (mres)
      cnt_q <= reload;
    else if (ar_now || ar_late)
      cnt_q <= reload;
    else
      cnt_q <= cnt_nx;
  end

  // ========================================================================
  // Total count, sign-extended adds
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tot_q <= 32'h0;
    else if (mres)
      tot_q <= tot_q + {{8{cnt_q[23]}}, cnt_q};
    else if (ar_now)
      tot_q <= tot_q + {{8{cnt_step[23]}}, cnt_step};
    else if (ar_late)
      tot_q <= tot_q + {{8{cnt_q[23]}}, cnt_q};
  end

  // ========================================================================
  // Output one and its timer; a new hit wins over a drop
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out1_q <= 1'b0;
      t1_q   <= 14'h0;
    end
    else if (mres)
      out1_q <= 1'b0;
    else if (hit1)
    begin
      out1_q <= 1'b1;
      t1_q   <= cfg_q.p1;
    end
    else if (p1_end || p2_end)
      out1_q <= 1'b0;
    else if (tick && t1_q != 14'h0)
      t1_q <= t1_q - 14'h1;
  end

  // ========================================================================
  // Output two and its timer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out2_q <= 1'b0;
      t2_q   <= 14'h0;
    end
    else if (mres)
      out2_q <= 1'b0;
    else if (hit2)
    begin
      out2_q <= 1'b1;
      t2_q   <= cfg_q.p2;
    end
    else if (p2_end)
      out2_q <= 1'b0;
    else if (tick && t2_q != 14'h0)
      t2_q <= t2_q - 14'h1;
  end

  // ========================================================================
  // Halt and display hold
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      halt_q <= 1'b0;
      hold_q <= 1'b0;
    end
    else
    begin
      if (mres || ar_late)
        halt_q <= 1'b0;
      else if (set_halt)
        halt_q <= 1'b1;
      // end point shown while output two
      if (mres || p2_end)
        hold_q <= 1'b0;
      else if (ar_now && cfg_q.mode == SPO_AR3)
        hold_q <= 1'b1;
    end
  end

  // Display lags the count by one cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      disp_q <= 24'h000000;
    else
      disp_q <= hold_q ? endpt : cnt_q;
  end

  // ========================================================================
  // Avalon slave: one wait cycle, answer registered
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;

  // Byte lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    return r;
  endfunction

  // Pulse value held within the documented range
  function automatic logic [13:0] clamp(input logic [31:0] v);
    logic [13:0] r;
    r = (v[31:14] != 18'h0 || v[13:0] > `SPO_PULSE_MAX) ? `SPO_PULSE_MAX : v[13:0];
    return r;
  endfunction

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  // Read mux; unmapped reads return zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h0;
    else if (avs_read && !ack_q)
      case (avs_address)
        `SPO_OFS_CTRL:   rdata_q <= {28'h0, cfg_q.down, cfg_q.mode};
        `SPO_OFS_SP1:    rdata_q <= {8'h0, cfg_q.sp1};
        `SPO_OFS_SP2:    rdata_q <= {8'h0, cfg_q.sp2};
        `SPO_OFS_PULSE1: rdata_q <= {18'h0, cfg_q.p1};
        `SPO_OFS_PULSE2: rdata_q <= {18'h0, cfg_q.p2};
        `SPO_OFS_COUNT:  rdata_q <= {{8{cnt_q[23]}}, cnt_q};
        `SPO_OFS_TOTAL:  rdata_q <= tot_q;
        `SPO_OFS_DISP:   rdata_q <= {8'h0, disp_q};
        `SPO_OFS_STATUS: rdata_q <= {28'h0, hold_q, halt_q, out2_q, out1_q};
        default:         rdata_q <= 32'h0;
      endcase
  end

  // Config writes take effect on the answer edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q.mode <= spo_mode_t'(`SPO_RST_MODE);
      cfg_q.down <= 1'b0;
      cfg_q.sp1  <= `SPO_RST_SP;
      cfg_q.sp2  <= `SPO_RST_SP;
      cfg_q.p1   <= `SPO_RST_PULSE;
      cfg_q.p2   <= `SPO_RST_PULSE;
    end
    else if (avs_write && ack_q)
      case (avs_address)
        `SPO_OFS_CTRL:
        begin
          // Codes 6 and 7 are not supported and fall back to manual one
          if (avs_byteenable[0])
          begin
            cfg_q.mode <= (avs_writedata[2:0] > 3'h5) ? SPO_MR1
                          : spo_mode_t'(avs_writedata[2:0]);
            cfg_q.down <= avs_writedata[`SPO_CTRL_DOWN_BIT];
          end
        end
        `SPO_OFS_SP1:
          cfg_q.sp1 <= 24'(merge({8'h0, cfg_q.sp1}, avs_writedata, avs_byteenable));
        `SPO_OFS_SP2:
          cfg_q.sp2 <= 24'(merge({8'h0, cfg_q.sp2}, avs_writedata, avs_byteenable));
        `SPO_OFS_PULSE1:
          cfg_q.p1 <= clamp(merge({18'h0, cfg_q.p1}, avs_writedata, avs_byteenable));
        `SPO_OFS_PULSE2:
          cfg_q.p2 <= clamp(merge({18'h0, cfg_q.p2}, avs_writedata, avs_byteenable));
        default:
          cfg_q.mode <= cfg_q.mode;
      endcase
  end

  // ========================================================================
  // Outputs
  assign avs_readdata = rdata_q;
  assign out1_on      = out1_q;
  assign out2_on      = out2_q;
  assign disp_value   = disp_q;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_hit1;
    !mres && hit1;
  endsequence

  sequence s_pulse2_done;
    !mres && !hit2 && !hit1 && p2_end;
  endsequence

  a_out1_on_hit: assert property (s_hit1 |=> out1_q && t1_q == $past(cfg_q.p1))
    else $error("output one not set at first setpoint");
  a_out1_pulse_end: assert property (!mres && !hit1 && p1_end |=> !out1_q)
    else $error("output one not dropped at pulse end");
  a_out1_zero_hold: assert property (out1_q && cfg_q.p1 == 14'h0 && !mres && !p2_end
                                     |=> out1_q)
    else $error("zero pulse output one dropped early");
  a_mr1_below_zero: assert property (cfg_q.mode == SPO_MR1 && cfg_q.down && adv
                                     && cnt_q == 24'h0 && !mres ##1 1'b1
                                     |-> cnt_q == 24'hffffff)
    else $error("manual one did not pass below zero");
  a_halt_stable: assert property (halt_q && !mres && !ar_late |=> $stable(cnt_q))
    else $error("count moved while halted");
  a_out2_drops_out1: assert property (s_pulse2_done |=> !out1_q && !out2_q)
    else $error("output one survived output two pulse end");
  a_mres_total: assert property (mres |=> tot_q == $past(tot_q) + {{8{$past(cnt_q[23])}},
                                 $past(cnt_q)} && cnt_q == $past(reload))
    else $error("manual reset total or reload wrong");
  a_ar_now_reload: assert property (ar_now && !mres |=> cnt_q == $past(reload)
                                    && out2_q)
    else $error("automatic reset did not reload at end point");
  a_no_auto_zero: assert property (is_auto && cfg_q.p2 == 14'h0 && hit2 && !mres
                                   |=> cnt_q == $past(cnt_step) && !halt_q)
    else $error("automatic reset with zero pulse two");
  a_ar2_late: assert property (ar_late && !mres |=> cnt_q == $past(reload) && !halt_q
                               && !out2_q)
    else $error("auto two reset at pulse end wrong");
  a_disp_hold: assert property (hold_q |=> disp_q == $past(endpt))
    else $error("display not holding end point");

endmodule

// ### spo_field_model.sv
// Purpose: Field sensor model for count, pause and manual reset pins
// Assumes: Pins change just after a rising mclk edge
// Notes:   Pulses stay 4 cycles high and low, above the 3 cycle minimum
`timescale 1ns/1ps
module spo_field_model
  import spo_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Pins toward the block
  output spo_pins_t field_in
);
  // ========================================
  // Idle pins low from time zero
  initial field_in = '0;

  // Wait n edges with pins held
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One count pulse
  task automatic step();
    @(posedge mclk);
    field_in.count <= 1'b1;
    hold(4);
    field_in.count <= 1'b0;
    hold(4);
  endtask

  // One manual reset pulse
  task automatic mreset();
    @(posedge mclk);
    field_in.mreset <= 1'b1;
    hold(4);
    field_in.mreset <= 1'b0;
    hold(4);
  endtask

  // Pause level, settled through the sync stages
  task automatic pause(input logic v);
    @(posedge mclk);
    field_in.pause <= v;
    hold(3);
  endtask
endmodule

// ### spo_setpoint_out_tb.sv
// Purpose: Self-checking bench for the setpoint output block
// Assumes: Pulse unit shortened to 4 mclk cycles
// Notes:   Totals are checked as deltas in the auto one test, as absolute values elsewhere
`timescale 1ns/1ps
`include "spo_cfg.svh"
module spo_setpoint_out_tb
  import spo_pkg::*;
;
  // ========================================
  // Bench signals
  logic        mclk;
  logic        rst_n;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  spo_pins_t   field_in;
  logic        out1_on;
  logic        out2_on;
  logic [23:0] disp_value;
  int          miscompares;  // Mismatches
  int          compares;     // Comparisons
  logic [31:0] t0;           // Total at test start

  // ========================================
  // Block and field sensors
  spo_setpoint_out #(.TICK_CYC(4)) i_spo_setpoint_out (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (4'hf),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .field_in        (field_in),
    .out1_on         (out1_on),
    .out2_on         (out2_on),
    .disp_value      (disp_value)
  );
  spo_field_model i_spo_field_model (
    .mclk     (mclk),
    .field_in (field_in)
  );

  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ========================================
  // Bus and compare helpers
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    // Hold until waitrequest samples low, bounded
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 40)
    begin
      miscompares++;
      $display("[FAIL] bus waitrequest expected 0 seen %b", avs_waitrequest);
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask

  // Outputs sampled once the edge has settled
  task automatic outs(input logic e1, input logic e2, input string nm);
    #1;
    chk(nm, {e1, e2}, {out1_on, out2_on});
  endtask

  // Wait for an output to drop, bounded
  task automatic wait_low(input logic sel, input string nm);
    int n;
    n = 0;
    while ((sel ? out2_on : out1_on) !== 1'b0 && n < 120)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(nm, 32'h0, {31'h0, sel ? out2_on : out1_on});
  endtask

  task automatic steps(input int n);
    repeat (n) i_spo_field_model.step();
  endtask

  // Setpoints fixed at 2 and 4, then a manual reset reloads
  task automatic cfg(input spo_mode_t m, input logic dn, input logic [13:0] p1,
                     input logic [13:0] p2);
    wr(`SPO_OFS_CTRL, {28'h0, dn, m});
    wr(`SPO_OFS_SP1, 32'h2);
    wr(`SPO_OFS_SP2, 32'h4);
    wr(`SPO_OFS_PULSE1, {18'h0, p1});
    wr(`SPO_OFS_PULSE2, {18'h0, p2});
    i_spo_field_model.mreset();
  endtask

  // ========================================
  // Scenarios
  task automatic t_reset();
    rd(`SPO_OFS_CTRL, 32'h0, "ctrl reset");
    rd(`SPO_OFS_SP2, 32'h0, "sp2 reset");
    rd(`SPO_OFS_TOTAL, 32'h0, "total reset");
    rd(6'h24, 32'h0, "unmapped");
    wr(`SPO_OFS_CTRL, 32'hf);
    rd(`SPO_OFS_CTRL, 32'h8, "mode fallback");
    wr(`SPO_OFS_PULSE1, 32'hffff);
    rd(`SPO_OFS_PULSE1, 32'h270f, "pulse clamp");  // clamp
    outs(1'b0, 1'b0, "outs reset");
    $display("test reset done");
  endtask

  task automatic t_mr1_up();
    cfg(SPO_MR1, 1'b0, 14'h0, 14'h8);
    steps(2);
    outs(1'b1, 1'b0, "mr1 out1");  // first setpoint
    steps(2);
    outs(1'b1, 1'b1, "mr1 out2");  // second setpoint
    i_spo_field_model.pause(1'b1);
    steps(1);
    i_spo_field_model.pause(1'b0);
    rd(`SPO_OFS_COUNT, 32'h4, "paused count");
    steps(1);
    repeat (60) @(posedge mclk);
    outs(1'b1, 1'b1, "mr1 held");  // zero pulse holds
    rd(`SPO_OFS_TOTAL, 32'h0, "total pre");
    i_spo_field_model.mreset();
    rd(`SPO_OFS_TOTAL, 32'h5, "total add");  // manual add
    rd(`SPO_OFS_COUNT, 32'h0, "up reload");  // up zero
    outs(1'b0, 1'b0, "mr1 cleared");
    $display("test mr1_up done");
  endtask

  task automatic t_mr1_dn();
    cfg(SPO_MR1, 1'b1, 14'h8, 14'h8);
    rd(`SPO_OFS_COUNT, 32'h4, "dn reload");  // down setpoint
    steps(2);
    outs(1'b1, 1'b0, "mr1 dn out1");  // down
    wait_low(1'b0, "out1 pulse");  // pulse end
    steps(2);
    outs(1'b0, 1'b1, "mr1 dn zero");  // at zero
    steps(1);
    rd(`SPO_OFS_COUNT, 32'hffffffff, "below zero");  // keeps counting
    $display("test mr1_dn done");
  endtask

  task automatic t_mr2();
    for (int dn = 0; dn < 2; dn++)
    begin
      cfg(SPO_MR2, dn[0], 14'h0, 14'h0);
      steps(5);
      outs(1'b1, 1'b1, "mr2 outs");
      rd(`SPO_OFS_COUNT, dn ? 32'h0 : 32'h4, "mr2 halt");  // halt
      i_spo_field_model.mreset();
      steps(1);
      rd(`SPO_OFS_COUNT, dn ? 32'h3 : 32'h1, "mr2 resume");  // resume
    end
    $display("test mr2 done");
  endtask

  task automatic t_mr3();
    cfg(SPO_MR3, 1'b0, 14'h0, 14'h8);
    steps(4);
    outs(1'b1, 1'b1, "mr3 outs");
    wait_low(1'b1, "mr3 out2 end");  // timed output two
    chk("out1 with out2", 32'h0, {31'h0, out1_on});  // drop together
    steps(1);
    rd(`SPO_OFS_COUNT, 32'h5, "mr3 count on");  // keeps counting
    $display("test mr3 done");
  endtask

  task automatic t_ar1();
    for (int dn = 0; dn < 2; dn++)
    begin
      cfg(SPO_AR1, dn[0], 14'h0, 14'h8);
      bus(1'b0, `SPO_OFS_TOTAL, 32'h0, t0);
      steps(4);
      outs(1'b1, 1'b1, "ar1 outs");
      rd(`SPO_OFS_COUNT, dn ? 32'h4 : 32'h0, "ar1 reload");
      rd(`SPO_OFS_TOTAL, t0 + (dn ? 32'h0 : 32'h4), "ar1 total");  // auto add
    end
    cfg(SPO_AR1, 1'b0, 14'h0, 14'h0);
    steps(4);
    rd(`SPO_OFS_COUNT, 32'h4, "no auto reset");  // zero pulse two
    $display("test ar1 done");
  endtask

  task automatic t_ar2();
    for (int dn = 0; dn < 2; dn++)
    begin
      cfg(SPO_AR2, dn[0], 14'h0, 14'h18);
      steps(5);
      outs(1'b1, 1'b1, "ar2 outs");
      rd(`SPO_OFS_COUNT, dn ? 32'h0 : 32'h4, "ar2 halt");  // halt
      wait_low(1'b1, "ar2 out2 end");
      outs(1'b0, 1'b0, "ar2 dropped");  // with output two
      rd(`SPO_OFS_COUNT, dn ? 32'h4 : 32'h0, "ar2 reload");  // reload
    end
    $display("test ar2 done");
  endtask

  task automatic t_ar3();
    cfg(SPO_AR3, 1'b0, 14'h0, 14'h8);
    steps(4);
    #1;
    chk("ar3 disp hold", 32'h4, {8'h0, disp_value});  // shows setpoint
    rd(`SPO_OFS_COUNT, 32'h0, "ar3 reset");  // count reset
    wait_low(1'b1, "ar3 out2 end");
    @(posedge mclk);
    #1;
    chk("ar3 disp live", 32'h0, {8'h0, disp_value});  // live again
    $display("test ar3 done");
  endtask

  // ========================================
  // Verdict and end of run
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    miscompares = 0;
    compares = 0;
    rst_n = 1'b0;
    avs_address = 6'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_mr1_up();
    t_mr1_dn();
    t_mr2();
    t_mr3();
    t_ar1();
    t_ar2();
    t_ar3();
    close_out();
  end

  // Watchdog, well beyond the expected run of roughly 1200 cycles
  initial
  begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    close_out();
  end
endmodule
